// ===== shared/psq_pkg.sv
// Purpose: constants and types shared by the program sequencer files
// Assumes: 100 MHz system clock, four phases per instruction cycle
// Notes:   vectors, register offsets and phase numbers live here; the dv files repeat some as literals
package psq_pkg;

	localparam int PSQ_PC_W      = 11;
	localparam int PSQ_ROM_WORDS = 2048;
	localparam int PSQ_WORD_W    = 16;
	localparam int PSQ_DATA_W    = 8;
	localparam int PSQ_STACK_LVL = 6;
	localparam int PSQ_PHASES    = 4;
	localparam int PSQ_PH_W      = 2;
	localparam int PSQ_IRQ_N     = 6;
	localparam int PSQ_PAGE_LSB  = 8;

	localparam logic [PSQ_PH_W-1:0] PSQ_PH_FETCH = 2'h0;
	localparam logic [PSQ_PH_W-1:0] PSQ_PH_LAST  = 2'h3;
	localparam logic [PSQ_PH_W-1:0] PSQ_PH_STEP  = 2'h1;

	localparam logic [PSQ_PC_W-1:0] PSQ_VEC_RESET = 11'h000;
	localparam logic [PSQ_PC_W-1:0] PSQ_VEC_EXT_A = 11'h004;
	localparam logic [PSQ_PC_W-1:0] PSQ_VEC_EXT_B = 11'h008;
	localparam logic [PSQ_PC_W-1:0] PSQ_VEC_TMR0  = 11'h00c;
	localparam logic [PSQ_PC_W-1:0] PSQ_VEC_TMR1  = 11'h010;
	localparam logic [PSQ_PC_W-1:0] PSQ_VEC_SER   = 11'h014;
	localparam logic [PSQ_PC_W-1:0] PSQ_VEC_MFUNC = 11'h018;
	localparam logic [PSQ_PC_W-1:0] PSQ_PC_ONE    = 11'h001;

	localparam logic [2:0] PSQ_LAST_PAGE = 3'h7;

	localparam logic [7:0] PSQ_OFS_COUNTER_LOW = 8'h06;
	localparam logic [7:0] PSQ_OFS_TABLE_PTR   = 8'h07;
	localparam logic [7:0] PSQ_OFS_TABLE_HIGH  = 8'h08;
	localparam logic [7:0] PSQ_RD_ZERO         = 8'h00;

	localparam logic [7:0] PSQ_TABLE_POINTER_RST = 8'h00;
	localparam logic [7:0] PSQ_TABLE_HIGH_BYTE_RST = 8'h00;

	typedef enum logic [2:0] {
		PSQ_OP_NONE     = 3'b000,
		PSQ_OP_JUMP     = 3'b001,
		PSQ_OP_CALL     = 3'b010,
		PSQ_OP_RET      = 3'b011,
		PSQ_OP_SKIP     = 3'b100,
		PSQ_OP_TRD_CUR  = 3'b101,
		PSQ_OP_TRD_LAST = 3'b110
	} psq_op_t;

	typedef enum logic [1:0] {
		PSQ_SLOT_RUN   = 2'b00,
		PSQ_SLOT_DUMMY = 2'b01,
		PSQ_SLOT_TABLE = 2'b10
	} psq_slot_t;

	function automatic logic [PSQ_PC_W-1:0] psq_vector(input int idx);
		case (idx)
			0:       psq_vector = PSQ_VEC_EXT_A;
			1:       psq_vector = PSQ_VEC_EXT_B;
			2:       psq_vector = PSQ_VEC_TMR0;
			3:       psq_vector = PSQ_VEC_TMR1;
			4:       psq_vector = PSQ_VEC_SER;
			default: psq_vector = PSQ_VEC_MFUNC;
		endcase
	endfunction : psq_vector

	function automatic logic [PSQ_PC_W-1:0] psq_table_addr(
		input logic [PSQ_PC_W-1:0] pc,
		input logic [7:0]          ptr,
		input logic                last);
		if (last)
			psq_table_addr = {PSQ_LAST_PAGE, ptr};
		else
			psq_table_addr = {pc[PSQ_PC_W-1:PSQ_PAGE_LSB], ptr};
	endfunction : psq_table_addr

endpackage : psq_pkg

// ===== rtl/psq_stack.sv
// Purpose: return address stack for the program sequencer
// Assumes: one push or one pop per request, never both
// Notes:   a push while full drops the oldest entry
`timescale 1ns/10ps
`default_nettype none
module psq_stack
	import psq_pkg::*;
#(
	parameter int DEPTH = PSQ_STACK_LVL,
	parameter int WIDTH = PSQ_PC_W
) (
	input  wire logic             clk,
	input  wire logic             sys_rst,
	input  wire logic             ce,
	input  wire logic             push,
	input  wire logic             pop,
	input  wire logic [WIDTH-1:0] push_data,
	output logic      [WIDTH-1:0] top,
	output logic                  full
);

	logic [WIDTH-1:0] entry_reg [DEPTH];
	logic [3:0]       count_reg;

	assign top = entry_reg[0];

	// shift array: entry 0 is the top, oldest falls off the far end
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			for (int i = 0; i < DEPTH; i++)
				entry_reg[i] <= '0;
		end else if (ce) begin
			if (push) begin
				entry_reg[0] <= push_data;
				for (int i = 1; i < DEPTH; i++)
					entry_reg[i] <= entry_reg[i-1];
			end else if (pop) begin
				for (int i = 0; i < DEPTH - 1; i++)
					entry_reg[i] <= entry_reg[i+1];
			end
		end
	end

	// level count saturates so later pops still see valid entries
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			count_reg <= 4'h0;
			full      <= 1'b0;
		end else if (ce) begin
			if (push && count_reg != 4'(DEPTH)) begin
				count_reg <= count_reg + 4'h1;
				full      <= (count_reg == 4'(DEPTH - 1));
			end else if (pop && count_reg != 4'h0) begin
				count_reg <= count_reg - 4'h1;
				full      <= 1'b0;
			end
		end
	end

endmodule : psq_stack
`default_nettype wire

// ===== rtl/psq_sequencer.sv
// Purpose: program sequencer, four-phase two-stage fetch/execute
// Assumes: rom_data valid by phase 3 for the address set at phase 0
// Notes:   decode lives outside; it answers through cmd_* per cycle
//
// How it works
// - four phases make one instruction cycle
// - fetch next while executing current instruction
// - counter changes cost a dummy cycle
// - eleven-bit counter covers 2048 words
// - counter increments after each program fetch, holds in the table slot
// - taken skip discards prefetch, counter plus two
// - reset clears counter to zero
// - external irqs vector to 004h, 008h
// - timer overflows vector to 00ch, 010h
// - serial irq vectors to 014h
// - multi-function irq vectors to 018h
// - vector only if active, enabled, stack free
// - low byte write jumps within page
// - jump/call load code field, return stack
// - current-page table address uses counter page
// - last-page table address forces page bits high
// - table low byte to memory, high to register
// - pointer set first; table read two cycles
// - program memory is 2048 words of 16
// - six-level stack, full push drops oldest
`timescale 1ns/10ps
`default_nettype none
module psq_sequencer
	import psq_pkg::*;
#(
	parameter int PC_W   = PSQ_PC_W,
	parameter int WORD_W = PSQ_WORD_W,
	parameter int IRQ_N  = PSQ_IRQ_N
) (
	input  wire logic              clk,
	input  wire logic              sys_rst,
	input  wire logic              ce,
	output logic [PSQ_PHASES-1:0]  phase_clk,
	output logic [PC_W-1:0]        rom_addr,
	input  wire logic [WORD_W-1:0] rom_data,
	output logic [WORD_W-1:0]      instr_word,
	output logic                   instr_valid,
	output logic [PC_W-1:0]        instr_addr,
	input  wire logic              cmd_valid,
	input  wire psq_op_t           cmd_op,
	input  wire logic [PC_W-1:0]   cmd_target,
	input  wire logic [IRQ_N-1:0]  irq_active,
	input  wire logic [IRQ_N-1:0]  irq_enable,
	output logic [IRQ_N-1:0]       irq_ack,
	output logic                   stack_full,
	input  wire logic [7:0]        reg_addr,
	input  wire logic              reg_wr_en,
	input  wire logic [7:0]        reg_wr_data,
	output logic [7:0]             reg_rd_data,
	output logic                   tbl_mem_wr,
	output logic [7:0]             tbl_mem_addr,
	output logic [7:0]             tbl_mem_data
);

	logic [PSQ_PH_W-1:0] phase_reg;
	logic [PC_W-1:0]     pc_reg;
	logic [PC_W-1:0]     pc_next;
	psq_slot_t           slot_reg;
	psq_slot_t           slot_next;
	logic [7:0]          table_pointer_reg;
	logic [7:0]          table_high_byte_reg;
	logic                tbl_last_reg;
	logic [7:0]          tbl_dest_reg;
	logic                tbl_last_next;
	logic                cycle_end;
	logic                fetch_edge;
	logic                pcl_wr;
	logic                push;
	logic                pop;
	logic [PC_W-1:0]     stack_top;
	logic                stack_full_w;
	logic [IRQ_N-1:0]    irq_req;
	logic [IRQ_N-1:0]    irq_take;
	logic [PC_W-1:0]     irq_vec;
	logic                irq_any;
	logic [PC_W-1:0]     ret_addr;
	logic                irq_go;

	// one place for the register address match, shared by writes and reads
	function automatic logic reg_hit(
		input logic [7:0] addr,
		input logic [7:0] offset);
		reg_hit = (addr == offset);
	endfunction : reg_hit

	assign fetch_edge = ce && (phase_reg == PSQ_PH_FETCH);
	assign cycle_end  = ce && (phase_reg == PSQ_PH_LAST);
	// low byte writes only land at the cycle end, like any pc load
	assign pcl_wr     = reg_wr_en && reg_hit(reg_addr, PSQ_OFS_COUNTER_LOW);
	// prefetched word sits at pc-1; that is where execution resumes
	assign ret_addr   = pc_reg - PSQ_PC_ONE;
	assign stack_full = stack_full_w;

	// phase counter and one-hot phase outputs
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			phase_reg <= PSQ_PH_FETCH;
			phase_clk <= '0;
		end else if (ce) begin
			phase_reg <= phase_reg + PSQ_PH_STEP;
			phase_clk <= '0;
			phase_clk[phase_reg + PSQ_PH_STEP] <= 1'b1;
		end
	end

	// interrupt request gating and fixed priority, lowest index wins
	always_comb begin
		irq_req  = irq_active & irq_enable;
		irq_take = '0;
		irq_vec  = PSQ_VEC_RESET;
		irq_any  = 1'b0;
		for (int i = IRQ_N - 1; i >= 0; i--) begin
			if (irq_req[i]) begin
				irq_take    = '0;
				irq_take[i] = 1'b1;
				irq_vec     = psq_vector(i);
				irq_any     = 1'b1;
			end
		end
	end

	// execute-stage decision taken at the end of each cycle
	always_comb begin
		pc_next       = pc_reg;
		slot_next     = PSQ_SLOT_RUN;
		push          = 1'b0;
		pop           = 1'b0;
		tbl_last_next = tbl_last_reg;
		irq_go        = 1'b0;
		case (slot_reg)
			PSQ_SLOT_RUN: begin
				if (pcl_wr) begin
					pc_next   = {pc_reg[PC_W-1:PSQ_PAGE_LSB], reg_wr_data};
					slot_next = PSQ_SLOT_DUMMY;
				end else if (cmd_valid) begin
					case (cmd_op)
						PSQ_OP_JUMP: begin
							pc_next   = cmd_target;
							slot_next = PSQ_SLOT_DUMMY;
						end
						PSQ_OP_CALL: begin
							pc_next   = cmd_target;
							push      = 1'b1;
							slot_next = PSQ_SLOT_DUMMY;
						end
						PSQ_OP_RET: begin
							pc_next   = stack_top;
							pop       = 1'b1;
							slot_next = PSQ_SLOT_DUMMY;
						end
						PSQ_OP_SKIP: begin
							// pc already two past the skip instruction
							slot_next = PSQ_SLOT_DUMMY;
						end
						PSQ_OP_TRD_CUR: begin
							tbl_last_next = 1'b0;
							slot_next     = PSQ_SLOT_TABLE;
						end
						PSQ_OP_TRD_LAST: begin
							tbl_last_next = 1'b1;
							slot_next     = PSQ_SLOT_TABLE;
						end
						default: begin
							slot_next = PSQ_SLOT_RUN;
						end
					endcase
				end
				// an irq rides on a plain instruction only, never a transfer
				if (slot_next == PSQ_SLOT_RUN && irq_any && !stack_full_w) begin
					pc_next   = irq_vec;
					irq_go    = 1'b1;
					push      = 1'b1;
					slot_next = PSQ_SLOT_DUMMY;
				end
			end
			PSQ_SLOT_DUMMY: begin
				slot_next = PSQ_SLOT_RUN;
			end
			PSQ_SLOT_TABLE: begin
				slot_next = PSQ_SLOT_RUN;
			end
			default: begin
				slot_next = PSQ_SLOT_DUMMY;
			end
		endcase
	end

	// program counter: increment at fetch, load at cycle end
	// the table slot holds pc so the word after the read resumes in order
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			pc_reg <= PSQ_VEC_RESET;
		end else if (fetch_edge) begin
			if (slot_reg != PSQ_SLOT_TABLE)
				pc_reg <= pc_reg + PSQ_PC_ONE;
		end else if (cycle_end) begin
			pc_reg <= pc_next;
		end
	end

	// rom address: program fetch, or table word in the table slot
	// only one rom port, hence the borrowed fetch and the second cycle
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			rom_addr <= PSQ_VEC_RESET;
		end else if (fetch_edge) begin
			if (slot_reg == PSQ_SLOT_TABLE)
				rom_addr <= psq_table_addr(pc_reg, table_pointer_reg,
					tbl_last_reg);
			else
				rom_addr <= pc_reg;
		end
	end

	// pipeline slot and instruction register
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			slot_reg    <= PSQ_SLOT_DUMMY;
			instr_word  <= '0;
			instr_addr  <= PSQ_VEC_RESET;
			instr_valid <= 1'b0;
		end else if (cycle_end) begin
			slot_reg    <= slot_next;
			instr_valid <= (slot_next == PSQ_SLOT_RUN);
			// the table slot keeps the word prefetched before it
			if (slot_reg != PSQ_SLOT_TABLE) begin
				instr_word <= rom_data;
				instr_addr <= rom_addr;
			end
		end
	end

	// table read set-up and completion
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			tbl_last_reg        <= 1'b0;
			tbl_dest_reg        <= '0;
			tbl_mem_wr          <= 1'b0;
			tbl_mem_addr        <= '0;
			tbl_mem_data        <= '0;
		end else if (ce) begin
			tbl_mem_wr <= 1'b0;
			if (cycle_end) begin
				tbl_last_reg <= tbl_last_next;
				if (slot_next == PSQ_SLOT_TABLE)
					tbl_dest_reg <= cmd_target[7:0];
				if (slot_reg == PSQ_SLOT_TABLE) begin
					tbl_mem_wr          <= 1'b1;
					tbl_mem_addr        <= tbl_dest_reg;
					tbl_mem_data        <= rom_data[7:0];
				end
			end
		end
	end

	// high byte is read-only; only a finished table read loads it
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			table_high_byte_reg <= PSQ_TABLE_HIGH_BYTE_RST;
		end else if (cycle_end && slot_reg == PSQ_SLOT_TABLE) begin
			table_high_byte_reg <= rom_data[WORD_W-1:8];
		end
	end

	// table pointer is plain storage; software loads it first
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			table_pointer_reg <= PSQ_TABLE_POINTER_RST;
		end else if (ce && reg_wr_en
			&& reg_hit(reg_addr, PSQ_OFS_TABLE_PTR)) begin
			table_pointer_reg <= reg_wr_data;
		end
	end

	// interrupt acknowledge pulse, one system clock wide
	// follows the execute decision itself so ack and vector never disagree
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			irq_ack <= '0;
		end else if (ce) begin
			irq_ack <= '0;
			if (cycle_end && irq_go)
				irq_ack <= irq_take;
		end
	end

	// register read port; the high byte register has no write path
	// low byte reads the executing address, not the prefetch counter
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			reg_rd_data <= PSQ_RD_ZERO;
		end else if (ce) begin
			if (reg_hit(reg_addr, PSQ_OFS_COUNTER_LOW))
				reg_rd_data <= instr_addr[7:0];
			else if (reg_hit(reg_addr, PSQ_OFS_TABLE_PTR))
				reg_rd_data <= table_pointer_reg;
			else if (reg_hit(reg_addr, PSQ_OFS_TABLE_HIGH))
				reg_rd_data <= table_high_byte_reg;
			else
				reg_rd_data <= PSQ_RD_ZERO;
		end
	end

	// stack steps only at the cycle end, together with the pc load
	psq_stack #(
		.DEPTH(PSQ_STACK_LVL),
		.WIDTH(PC_W)
	) u_stack (
		.clk      (clk),
		.sys_rst  (sys_rst),
		.ce       (cycle_end),
		.push     (push),
		.pop      (pop),
		.push_data(ret_addr),
		.top      (stack_top),
		.full     (stack_full_w)
	);

endmodule : psq_sequencer
`default_nettype wire

// ===== dv/psq_rom.sv
// Purpose: program memory model facing the sequencer
// Assumes: word content is a fixed function of its address
// Notes:   registered answer, one clk after the address moves
`timescale 1ns/10ps
`default_nettype none
module psq_rom
	import psq_pkg::*;
(
	input  wire logic                  clk,
	input  wire logic [PSQ_PC_W-1:0]   addr,
	output logic      [PSQ_WORD_W-1:0] data
);
	// upper bits vary with the page so table high bytes differ
	always_ff @(posedge clk) begin
		data <= {5'h15, addr};
	end
endmodule : psq_rom
`default_nettype wire

// ===== dv/psq_checker.sv
// Purpose: port assertions for the program sequencer
// Assumes: ce held high while the checks run
// Notes:   one clock domain, so default clocking and disable
`timescale 1ns/10ps
`default_nettype none
module psq_checker
	import psq_pkg::*;
(
	input wire logic          clk,
	input wire logic          sys_rst,
	input wire logic [3:0]    phase_clk,
	input wire logic [10:0]   rom_addr,
	input wire logic          instr_valid,
	input wire logic [10:0]   instr_addr,
	input wire logic          cmd_valid,
	input wire psq_op_t       cmd_op,
	input wire logic [10:0]   cmd_target,
	input wire logic [5:0]    irq_active,
	input wire logic [5:0]    irq_enable,
	input wire logic [5:0]    irq_ack,
	input wire logic          stack_full,
	input wire logic          tbl_mem_wr,
	input wire logic [7:0]    tbl_mem_addr
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (sys_rst);
	logic [10:0] ack_vec;
	logic        exe3;
	assign exe3 = phase_clk[3] && instr_valid && cmd_valid;
	always_comb begin
		ack_vec = 11'h000;
		for (int i = 0; i < 6; i++) begin
			if (irq_ack[i])
				ack_vec = 11'(4 * (i + 1));
		end
	end
	reset_start_a: assert property ($fell(sys_rst) |->
		rom_addr == 11'h000 && !instr_valid ##1 phase_clk == 4'h2)
		else $error("bad start after reset");
	phase_rot_a: assert property ($onehot(phase_clk) |=>
		phase_clk == {$past(phase_clk[2:0]), $past(phase_clk[3])})
		else $error("phase rotation broken");
	fetch_incr_a: assert property (phase_clk[1] && instr_valid |->
		rom_addr == instr_addr + 11'h001)
		else $error("fetch not sequential");
	jump_load_a: assert property (exe3 && (cmd_op == PSQ_OP_JUMP ||
		cmd_op == PSQ_OP_CALL) |-> ##1 !instr_valid
		##1 rom_addr == $past(cmd_target, 2))
		else $error("jump target not fetched");
	skip_two_a: assert property (exe3 && cmd_op == PSQ_OP_SKIP |->
		##1 !instr_valid ##1 rom_addr == $past(instr_addr, 2) + 11'h002)
		else $error("skip not plus two");
	last_page_a: assert property (exe3 && cmd_op == PSQ_OP_TRD_LAST |->
		##2 rom_addr[10:8] == PSQ_LAST_PAGE
		##3 tbl_mem_wr && tbl_mem_addr == $past(cmd_target[7:0], 5))
		else $error("last page read wrong");
	irq_vector_a: assert property (irq_ack != 6'h00 |->
		$onehot(irq_ack) && !instr_valid
		##1 irq_ack == 6'h00 && rom_addr == $past(ack_vec))
		else $error("vector wrong");
	irq_gate_a: assert property (irq_ack != 6'h00 |->
		(irq_ack & ~$past(irq_active & irq_enable)) == 6'h00
		&& $past(phase_clk[3] && instr_valid && !stack_full))
		else $error("vector taken without cause");
endmodule : psq_checker
bind psq_sequencer psq_checker u_psq_checker (.clk, .sys_rst, .phase_clk,
	.rom_addr, .instr_valid, .instr_addr, .cmd_valid, .cmd_op, .cmd_target,
	.irq_active, .irq_enable, .irq_ack, .stack_full, .tbl_mem_wr,
	.tbl_mem_addr);
`default_nettype wire

// ===== dv/tb.sv
// Purpose: self-checking bench for the program sequencer
// Assumes: ce tied high; rom model content known to the bench
// Notes:   judged by the address of each word that executes next
`timescale 1ns/10ps
`default_nettype none
module tb
	import psq_pkg::*;
;
	logic clk = 1'b0, sys_rst = 1'b1, cmd_valid = 1'b0, reg_wr_en = 1'b0;
	psq_op_t cmd_op = PSQ_OP_NONE;
	logic [10:0] cmd_target = 11'h000, rom_addr, instr_addr, cur, a0;
	logic [5:0] irq_active = 6'h00, irq_enable = 6'h00, irq_ack;
	logic [5:0] act = 6'h00, ena = 6'h00, ack;
	logic [7:0] reg_addr = 8'h00, reg_wr_data = 8'h00, reg_rd_data;
	logic [7:0] tbl_mem_addr, tbl_mem_data;
	logic [15:0] rom_data, instr_word, tw;
	logic [3:0] phase_clk;
	logic instr_valid, stack_full, tbl_mem_wr;
	int cycles = 0, mismatches = 0, total_checks = 0;
	psq_sequencer u_psq_sequencer (.clk, .sys_rst, .ce(1'b1), .phase_clk,
		.rom_addr, .rom_data, .instr_word, .instr_valid, .instr_addr,
		.cmd_valid, .cmd_op, .cmd_target, .irq_active, .irq_enable, .irq_ack,
		.stack_full, .reg_addr, .reg_wr_en, .reg_wr_data, .reg_rd_data,
		.tbl_mem_wr, .tbl_mem_addr, .tbl_mem_data);
	psq_rom u_psq_rom (.clk, .addr(rom_addr), .data(rom_data));
	always #5 clk = ~clk;
	// a hang in any wait loop ends here instead of running on
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			mismatches++;
			summarize();
		end
	end
	function automatic logic [15:0] rw(input logic [10:0] x);
		return {5'h15, x};
	endfunction : rw
	task automatic summarize();
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : summarize
	task automatic chk(input logic ok);
		total_checks++;
		if (ok !== 1'b1) begin
			mismatches++;
			$display("ERROR %0t mismatch near %h", $time, cur);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wr_data <= d;
		reg_wr_en <= 1'b1;
		@(posedge clk);
		reg_wr_en <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk);
		reg_addr <= a;
		@(posedge clk);
		@(negedge clk);
		d = reg_rd_data;
	endtask : rd
	// waits for phase 2 of an executing cycle; next edge is phase 2
	task automatic sync();
		int i;
		i = 0;
		while (!(phase_clk[2] === 1'b1 && instr_valid === 1'b1) && i < 99) begin
			@(negedge clk);
			i++;
		end
		cur = instr_addr;
		chk(instr_word === rw(cur));
	endtask : sync
	task automatic step(input psq_op_t op, input logic [10:0] tgt,
		input logic w, input logic [7:0] wd, input int cyc);
		int n;
		sync();
		a0 = cur;
		@(posedge clk);
		cmd_valid <= op != PSQ_OP_NONE;
		cmd_op <= op;
		cmd_target <= tgt;
		reg_wr_en <= w;
		reg_addr <= PSQ_OFS_COUNTER_LOW;
		reg_wr_data <= wd;
		irq_active <= act;
		irq_enable <= ena;
		@(posedge clk);
		cmd_valid <= 1'b0;
		reg_wr_en <= 1'b0;
		n = 1;
		ack = 6'h00;
		while (!(phase_clk[2] === 1'b1 && instr_valid === 1'b1) && n < 40) begin
			@(negedge clk);
			n++;
			if (irq_ack !== 6'h00)
				ack = irq_ack;
			if (tbl_mem_wr === 1'b1)
				tw = {tbl_mem_addr, tbl_mem_data};
		end
		chk(n === 4 * cyc);
		sync();
	endtask : step
	task automatic t_flow();
		logic [10:0] p;
		logic [7:0]  d;
		sync();
		chk(cur === PSQ_VEC_RESET);
		step(PSQ_OP_NONE, 11'h000, 1'b0, 8'h00, 1);
		chk(cur === a0 + 11'h001);
		step(PSQ_OP_JUMP, 11'h7f0, 1'b0, 8'h00, 2);
		chk(cur === 11'h7f0);
		step(PSQ_OP_CALL, 11'h2fe, 1'b0, 8'h00, 2);
		step(PSQ_OP_NONE, 11'h000, 1'b0, 8'h00, 1);
		step(PSQ_OP_NONE, 11'h000, 1'b0, 8'h00, 1);
		chk(cur === 11'h300);
		step(PSQ_OP_RET, 11'h000, 1'b0, 8'h00, 2);
		chk(cur === 11'h7f1);
		step(PSQ_OP_SKIP, 11'h000, 1'b0, 8'h00, 2);
		chk(cur === a0 + 11'h002);
		step(PSQ_OP_NONE, 11'h000, 1'b1, 8'h40, 2);
		p = a0 + 11'h002;
		chk(cur === {p[10:8], 8'h40});
		rd(PSQ_OFS_COUNTER_LOW, d);
		chk(d === cur[7:0]);
	endtask : t_flow
	task automatic t_table();
		logic [7:0] d, ptr;
		logic [10:0] p;
		logic [15:0] w;
		rd(PSQ_OFS_TABLE_PTR, d);
		chk(d === PSQ_TABLE_POINTER_RST);
		wr(PSQ_OFS_TABLE_HIGH, 8'hc3);
		rd(PSQ_OFS_TABLE_HIGH, d);
		chk(d === PSQ_TABLE_HIGH_BYTE_RST);
		rd(8'h09, d);
		chk(d === PSQ_RD_ZERO);
		for (int k = 0; k < 2; k++) begin
			ptr = (k == 0) ? 8'h33 : 8'h9c;
			wr(PSQ_OFS_TABLE_PTR, ptr);
			tw = 16'h0000;
			step(k ? PSQ_OP_TRD_LAST : PSQ_OP_TRD_CUR, 11'h055, 1'b0, 8'h00, 2);
			chk(cur === a0 + 11'h001);
			p = a0 + 11'h002;
			w = rw({(k == 0) ? p[10:8] : 3'h7, ptr});
			chk(tw === {8'h55, w[7:0]});
			rd(PSQ_OFS_TABLE_HIGH, d);
			chk(d === w[15:8]);
		end
	endtask : t_table
	task automatic t_irq();
		logic [10:0] back;
		ena = 6'h3f;
		for (int i = 0; i < 6; i++) begin
			act = 6'h20 | (6'h01 << i);
			step(PSQ_OP_NONE, 11'h000, 1'b0, 8'h00, 2);
			back = a0 + 11'h001;
			chk(ack === (6'h01 << i));
			chk(cur === 11'(4 * (i + 1)));
			act = 6'h00;
			step(PSQ_OP_RET, 11'h000, 1'b0, 8'h00, 2);
			chk(cur === back);
		end
		ena = 6'h3e;
		act = 6'h01;
		step(PSQ_OP_NONE, 11'h000, 1'b0, 8'h00, 1);
		chk(ack === 6'h00);
		act = 6'h00;
		ena = 6'h3f;
	endtask : t_irq
	task automatic t_stack();
		for (int i = 0; i < 6; i++)
			step(PSQ_OP_CALL, 11'h100 + 11'(i * 16), 1'b0, 8'h00, 2);
		chk(stack_full === 1'b1);
		act = 6'h01;
		step(PSQ_OP_NONE, 11'h000, 1'b0, 8'h00, 1);
		chk(ack === 6'h00);
		act = 6'h00;
		// full push drops the oldest, so the last pop lands on 101
		step(PSQ_OP_CALL, 11'h400, 1'b0, 8'h00, 2);
		for (int j = 0; j < 6; j++) begin
			step(PSQ_OP_RET, 11'h000, 1'b0, 8'h00, 2);
			chk(cur === ((j == 0) ? 11'h152 : 11'h151 - 11'(16 * j)));
		end
	endtask : t_stack
	initial begin
		repeat (16) @(posedge clk);
		sys_rst <= 1'b0;
		t_flow();
		t_table();
		t_irq();
		t_stack();
		summarize();
	end
endmodule : tb
`default_nettype wire
